// >>> design/pxe_expander.sv
// serial-bus target of a 24-pin port expander with command pointer
// assumes scl, sda, strap and pins arrive asynchronous to i_clk_sys,
// and that the bench resolves the open-drain sda and push-pull pins
//
// What this block does
// - start resets bit state for address
// - stop returns to idle
// - matching address gets acknowledge on ninth clock
// - sda changes only while scl low
// - eight bits then one acknowledge, unlimited
// - sender releases sda before acknowledge
// - every received byte acknowledged
// - after nack device releases sda
// - address 010001 plus strap, msb first
// - address bit 0 high means read
// - first write byte loads the pointer
// - pointer bit 7 is autostep flag
// - pointer resets to 0x00
// - autostep advances low two pointer bits
// - fourth byte wraps to first bank
// - autostep skips reserved locations
// - flag clear keeps pointer fixed
// - input pin has both drivers off
// - output pin driven from output bank
// - reset restores defaults, pins inputs
// - codes 00-02 read pins, ignore writes
// - codes 04-06 output banks, read flops
// - codes 08-0a invert reported input level
// - codes 0c-0e direction, 03/07/0b/0f reserved
`timescale 1ns/1ps

module pxe_expander
    import pxe_pkg::*;
#(
    parameter int N_BANKS = `PXE_BANKS
) (
    // clock and reset
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_resetn,
    // serial bus, open drain
    input  wire logic                 i_scl,
    input  wire logic                 i_sda,
    output logic                      o_sda,
    output logic                      o_sda_oe_n,
    // address strap
    input  wire logic                 i_addr_sel,
    // port pins
    input  wire logic [`PXE_PINS-1:0] i_bank_pin,
    output logic      [`PXE_PINS-1:0] o_bank_pin,
    output logic      [`PXE_PINS-1:0] o_bank_pin_oe_n
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (N_BANKS != `PXE_BANKS) begin : g_bad_banks
        $error("pxe_expander serves exactly three banks");
    end

    pxe_state_t st;
    pxe_state_t n;

    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;
    logic       addr_match;
    logic       ptr_legal;
    logic [4:0] bank_off;
    logic [7:0] rd_byte;

    // ----------------------------------------------------------------
    // bus events from filtered lines
    // ----------------------------------------------------------------
    assign scl_rise = st.scl_f & ~st.scl_d;
    assign scl_fall = ~st.scl_f & st.scl_d;
    // sda moving while scl stays high is never data
    assign start_ev = st.scl_f & st.scl_d & st.sda_d & ~st.sda_f;
    assign stop_ev  = st.scl_f & st.scl_d & ~st.sda_d & st.sda_f;
    assign addr_match = (st.shift[7:1] == {`PXE_ADDR_BASE, st.adr_f});

    // nonzero pointer bits 6:4 or bank 3 never touch storage
    assign ptr_legal = (st.ptr[6:4] == 3'h0) && (st.ptr[1:0] <= `PXE_BANK_LAST);
    assign bank_off  = {st.ptr[1:0], 3'h0};

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        if (ptr_legal) begin
            unique case (st.ptr[`PXE_GRP_HI:`PXE_GRP_LO])
                `PXE_GRP_INPUT:  rd_byte = st.pin_f[bank_off +: 8] ^ st.inv[bank_off +: 8];
                `PXE_GRP_OUTPUT: rd_byte = st.outv[bank_off +: 8];
                `PXE_GRP_INVERT: rd_byte = st.inv[bank_off +: 8];
                `PXE_GRP_DIR:    rd_byte = st.dir[bank_off +: 8];
            endcase
        end
    end

    // autostep walks banks 0..2 and wraps, never landing on bank 3
    function automatic logic [7:0] pxe_step(input logic [7:0] p);
        logic [7:0] r;
        r = p;
        if (p[`PXE_AUTOSTEP_BIT]) begin
            if (p[1:0] >= `PXE_BANK_LAST) begin
                r[1:0] = 2'h0;
            end else begin
                r[1:0] = p[1:0] + 2'h1;
            end
        end
        return r;
    endfunction : pxe_step

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n = st;
        n.sda_lvl = 1'b0;
        // three-stage synchronisers; a change counts when stages two and three agree
        n.scl_sy = {st.scl_sy[1:0], i_scl};
        n.sda_sy = {st.sda_sy[1:0], i_sda};
        n.adr_sy = {st.adr_sy[1:0], i_addr_sel};
        n.pin_s1 = i_bank_pin;
        n.pin_s2 = st.pin_s1;
        n.pin_s3 = st.pin_s2;
        if (st.scl_sy[1] == st.scl_sy[2]) begin
            n.scl_f = st.scl_sy[2];
        end
        if (st.sda_sy[1] == st.sda_sy[2]) begin
            n.sda_f = st.sda_sy[2];
        end
        if (st.adr_sy[1] == st.adr_sy[2]) begin
            n.adr_f = st.adr_sy[2];
        end
        n.pin_f = (~(st.pin_s2 ^ st.pin_s3) & st.pin_s3) | ((st.pin_s2 ^ st.pin_s3) & st.pin_f);
        n.scl_d = st.scl_f;
        n.sda_d = st.sda_f;

        if (stop_ev) begin
            n.phase    = PH_IDLE;
            n.sda_oe_n = 1'b1;
        end else if (start_ev) begin
            n.phase    = PH_ADDR;
            n.bcnt     = 4'h0;
            n.nack     = 1'b0;
            n.sda_oe_n = 1'b1;
        end else if (st.phase != PH_IDLE && st.phase != PH_SKIP) begin
            if (scl_rise) begin
                if (st.bcnt < `PXE_ACK_SLOT && st.phase != PH_RD) begin
                    n.shift = {st.shift[6:0], st.sda_f};
                end
                if (st.bcnt == `PXE_ACK_SLOT && st.phase == PH_RD) begin
                    n.nack = st.sda_f;
                    n.ptr  = pxe_step(st.ptr);
                end
                n.bcnt = st.bcnt + 4'h1;
            end else if (scl_fall) begin
                if (st.bcnt == `PXE_ACK_SLOT) begin
                    unique case (st.phase)
                        PH_ADDR: begin
                            if (addr_match) begin
                                n.rw       = st.shift[0];
                                n.sda_oe_n = 1'b0;
                            end else begin
                                n.phase = PH_SKIP;
                            end
                        end
                        PH_CMD: begin
                            n.ptr      = st.shift;
                            n.sda_oe_n = 1'b0;
                        end
                        PH_WR: begin
                            if (ptr_legal) begin
                                unique case (st.ptr[`PXE_GRP_HI:`PXE_GRP_LO])
                                    `PXE_GRP_INPUT:  ;
                                    `PXE_GRP_OUTPUT: n.outv[bank_off +: 8] = st.shift;
                                    `PXE_GRP_INVERT: n.inv[bank_off +: 8] = st.shift;
                                    `PXE_GRP_DIR:    n.dir[bank_off +: 8] = st.shift;
                                endcase
                            end
                            n.ptr      = pxe_step(st.ptr);
                            n.sda_oe_n = 1'b0;
                        end
                        PH_RD: begin
                            n.sda_oe_n = 1'b1;
                        end
                        default: begin
                            n.sda_oe_n = 1'b1;
                        end
                    endcase
                end else if (st.bcnt == `PXE_ACK_END) begin
                    n.bcnt     = 4'h0;
                    n.sda_oe_n = 1'b1;
                    unique case (st.phase)
                        PH_ADDR: begin
                            if (st.rw == `PXE_RW_READ) begin
                                n.phase    = PH_RD;
                                n.shift    = rd_byte;
                                n.sda_oe_n = rd_byte[7];
                            end else begin
                                n.phase = PH_CMD;
                            end
                        end
                        PH_CMD: n.phase = PH_WR;
                        PH_WR:  n.phase = PH_WR;
                        PH_RD: begin
                            if (st.nack) begin
                                n.phase = PH_SKIP;
                            end else begin
                                n.shift    = rd_byte;
                                n.sda_oe_n = rd_byte[7];
                            end
                        end
                        default: n.phase = PH_SKIP;
                    endcase
                end else if (st.phase == PH_RD && st.bcnt != 4'h0) begin
                    // next data bit goes out only while scl is low
                    n.shift    = {st.shift[6:0], 1'b0};
                    n.sda_oe_n = st.shift[6];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st          <= '0;
            st.scl_sy   <= 3'h7;
            st.sda_sy   <= 3'h7;
            st.scl_f    <= 1'b1;
            st.scl_d    <= 1'b1;
            st.sda_f    <= 1'b1;
            st.sda_d    <= 1'b1;
            st.phase    <= PH_IDLE;
            st.ptr      <= `PXE_PTR_RESET;
            st.outv     <= `PXE_OUT_RESET;
            st.inv      <= `PXE_INV_RESET;
            st.dir      <= `PXE_DIR_RESET;
            st.sda_oe_n <= 1'b1;
        end else begin
            st <= n;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_sda           = st.sda_lvl;
    assign o_sda_oe_n      = st.sda_oe_n;
    // one driver on per output pin, both off for an input
    assign o_bank_pin      = st.outv;
    assign o_bank_pin_oe_n = st.dir;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    a_start_rearm: assert property (start_ev && !stop_ev |=>
        st.phase == PH_ADDR && st.bcnt == 4'h0 && st.sda_oe_n)
        else $error("start did not rearm address reception");

    a_stop_idle: assert property (stop_ev |=> st.phase == PH_IDLE && st.sda_oe_n)
        else $error("stop did not return to idle");

    a_addr_ack: assert property (st.phase == PH_ADDR && scl_fall &&
        st.bcnt == `PXE_ACK_SLOT && addr_match && !start_ev && !stop_ev
        |=> !st.sda_oe_n)
        else $error("matching address not acknowledged");

    a_addr_skip: assert property (st.phase == PH_ADDR && scl_fall &&
        st.bcnt == `PXE_ACK_SLOT && !addr_match && !start_ev && !stop_ev
        |=> st.phase == PH_SKIP && st.sda_oe_n)
        else $error("foreign address was answered");

    a_drive_scl_low: assert property ($fell(st.sda_oe_n) |-> !st.scl_f)
        else $error("sda pulled low while scl high");

    a_byte_ack: assert property ((st.phase == PH_CMD || st.phase == PH_WR) &&
        scl_fall && st.bcnt == `PXE_ACK_SLOT && !start_ev && !stop_ev
        |=> !st.sda_oe_n ##1 !st.sda_oe_n)
        else $error("received byte not acknowledged");

    a_read_release: assert property (st.phase == PH_RD && scl_fall &&
        st.bcnt == `PXE_ACK_SLOT && !start_ev && !stop_ev
        |=> st.sda_oe_n)
        else $error("device held sda into the master acknowledge");

    a_nack_release: assert property (st.phase == PH_RD && scl_rise &&
        st.bcnt == `PXE_ACK_SLOT && st.sda_f && !stop_ev
        |=> st.sda_oe_n && st.nack)
        else $error("device kept sda after nack");

    a_nack_skip: assert property (st.phase == PH_RD && scl_fall &&
        st.bcnt == `PXE_ACK_END && st.nack && !start_ev && !stop_ev
        |=> st.phase == PH_SKIP && st.sda_oe_n)
        else $error("device went on sending after nack");

    a_cmd_store: assert property (st.phase == PH_CMD && scl_fall &&
        st.bcnt == `PXE_ACK_SLOT && !start_ev && !stop_ev
        |=> st.ptr == $past(st.shift))
        else $error("command byte not stored");

    a_step_next: assert property (st.phase == PH_WR && scl_fall &&
        st.bcnt == `PXE_ACK_SLOT && st.ptr[7] && st.ptr[1:0] < 2'h2 &&
        !start_ev && !stop_ev |=> st.ptr[1:0] == $past(st.ptr[1:0]) + 2'h1)
        else $error("autostep did not advance the bank");

    a_step_wrap: assert property (st.phase == PH_WR && scl_fall &&
        st.bcnt == `PXE_ACK_SLOT && st.ptr[7] && st.ptr[1:0] == 2'h2 &&
        !start_ev && !stop_ev |=> st.ptr[1:0] == 2'h0)
        else $error("autostep did not wrap to bank 0");

    a_no_step: assert property (st.phase == PH_WR && scl_fall &&
        st.bcnt == `PXE_ACK_SLOT && !st.ptr[7] && !start_ev && !stop_ev
        |=> $stable(st.ptr))
        else $error("pointer moved with autostep clear");

    a_input_ro: assert property (st.phase == PH_WR && scl_fall &&
        st.bcnt == `PXE_ACK_SLOT && st.ptr[3:2] == 2'h0
        |=> $stable(st.outv) && $stable(st.inv) && $stable(st.dir))
        else $error("write to input bank changed storage");

    a_write_lands: assert property (st.phase == PH_WR && scl_fall &&
        st.bcnt == `PXE_ACK_SLOT && st.ptr[6:0] == 7'h04 && !start_ev && !stop_ev
        |=> st.outv[7:0] == $past(st.shift))
        else $error("output bank write lost");

    // main bus scenarios
    c_write_data: cover property (st.phase == PH_WR && scl_fall && st.bcnt == `PXE_ACK_SLOT);
    c_read_acked: cover property (st.phase == PH_RD && scl_fall &&
        st.bcnt == `PXE_ACK_END && !st.nack);
    c_read_nack: cover property (st.phase == PH_SKIP && st.nack && stop_ev);
    c_restart: cover property (st.phase == PH_WR && start_ev);

endmodule : pxe_expander

// >>> design/pxe_consts.svh
// constants for the serial port expander: pointer layout, bank codes, reset values
// assumes nothing; included by the package and the testbench
`ifndef PXE_CONSTS_SVH
`define PXE_CONSTS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PXE_PINS        24
`define PXE_BANK_W      8
`define PXE_BANKS       3

// ----------------------------------------------------------------
// target address: fixed upper six bits, strap supplies the seventh
// ----------------------------------------------------------------
`define PXE_ADDR_BASE   6'h11
`define PXE_RW_READ     1'b1

// ----------------------------------------------------------------
// command pointer fields
// ----------------------------------------------------------------
`define PXE_AUTOSTEP_BIT 7
`define PXE_GRP_HI      3
`define PXE_GRP_LO      2
`define PXE_GRP_INPUT   2'h0
`define PXE_GRP_OUTPUT  2'h1
`define PXE_GRP_INVERT  2'h2
`define PXE_GRP_DIR     2'h3
`define PXE_BANK_LAST   2'h2

// ----------------------------------------------------------------
// reset values and bit slots
// ----------------------------------------------------------------
`define PXE_PTR_RESET   8'h00
`define PXE_OUT_RESET   24'hffffff
`define PXE_INV_RESET   24'h000000
`define PXE_DIR_RESET   24'hffffff
`define PXE_ACK_SLOT    4'h8
`define PXE_ACK_END     4'h9

`endif

// >>> design/pxe_pkg.sv
// types for the serial port expander
// assumes pxe_consts.svh on the include path
package pxe_pkg;
    `include "pxe_consts.svh"

    typedef enum logic [2:0] {
        PH_IDLE, PH_ADDR, PH_CMD, PH_WR, PH_RD, PH_SKIP
    } pxe_phase_t;

    typedef struct packed {
        logic [2:0]           scl_sy;
        logic [2:0]           sda_sy;
        logic [2:0]           adr_sy;
        logic [`PXE_PINS-1:0] pin_s1;
        logic [`PXE_PINS-1:0] pin_s2;
        logic [`PXE_PINS-1:0] pin_s3;
        logic [`PXE_PINS-1:0] pin_f;
        logic                 scl_f;
        logic                 scl_d;
        logic                 sda_f;
        logic                 sda_d;
        logic                 adr_f;
        pxe_phase_t           phase;
        logic [3:0]           bcnt;
        logic [7:0]           shift;
        logic                 rw;
        logic                 nack;
        logic [7:0]           ptr;
        logic [`PXE_PINS-1:0] outv;
        logic [`PXE_PINS-1:0] inv;
        logic [`PXE_PINS-1:0] dir;
        logic                 sda_oe_n;
        logic                 sda_lvl;
    } pxe_state_t;
endpackage : pxe_pkg

// >>> test/pxe_bus_master.sv
// bus master model: drives scl, pulls or releases sda, samples the wire
// assumes sda is resolved outside with a pull-up; one bit takes 16 clocks
`timescale 1ns/1ps

module pxe_bus_master (
    // clock
    input  wire logic i_clk_sys,
    // serial bus
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_rel
);
    // ----------------------------------------------------------------
    // idle bus
    // ----------------------------------------------------------------
    initial begin
        o_scl     = 1'b1;
        o_sda_rel = 1'b1;
    end

    // ----------------------------------------------------------------
    // bus phases
    // ----------------------------------------------------------------
    task automatic put(input logic scl, input logic sda, input int n);
        o_scl     <= scl;
        o_sda_rel <= sda;
        repeat (n) @(posedge i_clk_sys);
    endtask : put

    // sda moves mid-low phase only, well clear of both scl edges
    task automatic bit_io(input logic b, output logic s);
        put(1'b0, o_sda_rel, 4);
        put(1'b0, b, 4);
        put(1'b1, b, 8);
        s = i_sda;
    endtask : bit_io

    task automatic bus_start();
        put(1'b0, o_sda_rel, 4);
        put(1'b0, 1'b1, 4);
        put(1'b1, 1'b1, 8);
        put(1'b1, 1'b0, 8);
        put(1'b0, 1'b0, 8);
    endtask : bus_start

    task automatic bus_stop();
        put(1'b0, o_sda_rel, 4);
        put(1'b0, 1'b0, 4);
        put(1'b1, 1'b0, 8);
        put(1'b1, 1'b1, 8);
    endtask : bus_stop

    // ninth bit: 1 releases the line (writes, nack), 0 acknowledges a read
    task automatic xfer(input logic [7:0] tx, input logic nine,
                        output logic [7:0] rx, output logic s9);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(nine, s9);
    endtask : xfer
endmodule : pxe_bus_master

// >>> test/testbench.sv
// self-checking bench: bus master model on sda/scl, pins looped back
// assumes pxe_bus_master and the design sources are compiled first
`timescale 1ns/1ps
`include "pxe_consts.svh"

module testbench
    import pxe_pkg::*;
;
    // ----------------------------------------------------------------
    // clock, reset and wires
    // ----------------------------------------------------------------
    logic        i_clk_sys;
    logic        i_resetn;
    logic        strap;
    logic [23:0] ext_pin;
    logic        scl_m;
    logic        rel_m;
    logic        sda_oe_n;
    logic        sda_dv;
    logic [23:0] pin_q;
    logic [23:0] pin_oe_n;
    wire         scl_w;
    wire         sda_w;
    wire  [23:0] pin_w;
    int          mismatches;
    int          comparisons;

    // bus lines lag the clock so their edges land between its edges
    assign #3 scl_w = scl_m;
    assign #3 sda_w = rel_m & (sda_oe_n | sda_dv);
    assign pin_w = (pin_oe_n & ext_pin) | (~pin_oe_n & pin_q);

    pxe_expander #(.N_BANKS(3)) i_pxe_expander (
        .i_clk_sys       (i_clk_sys),
        .i_resetn        (i_resetn),
        .i_scl           (scl_w),
        .i_sda           (sda_w),
        .o_sda           (sda_dv),
        .o_sda_oe_n      (sda_oe_n),
        .i_addr_sel      (strap),
        .i_bank_pin      (pin_w),
        .o_bank_pin      (pin_q),
        .o_bank_pin_oe_n (pin_oe_n)
    );

    pxe_bus_master i_pxe_bus_master (
        .i_clk_sys (i_clk_sys),
        .i_sda     (sda_w),
        .o_scl     (scl_m),
        .o_sda_rel (rel_m)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset();
        i_resetn <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
    endtask : do_reset

    task automatic send(input logic [7:0] b, input logic ack);
        logic [7:0] rx;
        logic       s;
        i_pxe_bus_master.xfer(b, 1'b1, rx, s);
        chk({23'h0, ~s}, {23'h0, ack});
    endtask : send

    task automatic wr(input logic [7:0] q[$]);
        i_pxe_bus_master.bus_start();
        send({`PXE_ADDR_BASE, strap, 1'b0}, 1'b1);
        foreach (q[i]) send(q[i], 1'b1);
        i_pxe_bus_master.bus_stop();
    endtask : wr

    // cmd ff skips the pointer write and reads from the current pointer
    task automatic rd(input logic [7:0] cmd, input logic [7:0] e[$]);
        logic [7:0] rx;
        logic       s;
        // pointer set by a write, then a repeated start turns the bus around
        if (cmd !== 8'hff) begin
            i_pxe_bus_master.bus_start();
            send({`PXE_ADDR_BASE, strap, 1'b0}, 1'b1);
            send(cmd, 1'b1);
        end
        i_pxe_bus_master.bus_start();
        send({`PXE_ADDR_BASE, strap, `PXE_RW_READ}, 1'b1);
        foreach (e[i]) begin
            i_pxe_bus_master.xfer(8'hff, i == e.size() - 1, rx, s);
            chk({16'h0, rx}, {16'h0, e[i]});
        end
        chk({23'h0, sda_oe_n}, 24'h1);
        // a device that ignored the nack would start its next byte here
        i_pxe_bus_master.put(1'b0, 1'b1, 8);
        chk({23'h0, sda_oe_n}, 24'h1);
        i_pxe_bus_master.bus_stop();
    endtask : rd

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (90000) @(posedge i_clk_sys);
        mismatches++;
        report_and_stop();
    end

    initial begin
        i_resetn    = 1'b0;
        strap       = 1'b0;
        ext_pin     = 24'h123456;
        mismatches  = 0;
        comparisons = 0;
        @(posedge i_clk_sys);
        do_reset();
        chk(pin_oe_n, 24'hffffff);
        chk(pin_q, 24'hffffff);
        chk({23'h0, sda_oe_n}, 24'h1);
        rd(8'hff, '{8'h56, 8'h56});
        i_pxe_bus_master.bus_start();
        send(8'h46, 1'b0);
        i_pxe_bus_master.bus_stop();
        // strap only moves while the bus is idle
        strap <= 1'b1;
        i_pxe_bus_master.bus_start();
        send(8'h44, 1'b0);
        i_pxe_bus_master.bus_stop();
        rd(8'h8c, '{8'hff, 8'hff, 8'hff, 8'hff});
        rd(8'h88, '{8'h00, 8'h00, 8'h00});
        wr('{8'h84, 8'h11, 8'h22, 8'h33, 8'h44});
        chk(pin_q, 24'h332244);
        rd(8'h84, '{8'h44, 8'h22, 8'h33, 8'h44});
        rd(8'h86, '{8'h33, 8'h44});
        wr('{8'h80, 8'h99, 8'h98});
        rd(8'h04, '{8'h44, 8'h44});
        wr('{8'h0c, 8'h0f, 8'h00});
        chk(pin_oe_n, 24'hffff00);
        rd(8'h00, '{8'h44});
        wr('{8'h8a, 8'hf0});
        rd(8'h02, '{8'he2});
        do_reset();
        chk(pin_oe_n, 24'hffffff);
        chk(pin_q, 24'hffffff);
        rd(8'hff, '{8'h56});
        report_and_stop();
    end
endmodule : testbench
